// ===== core/rlbg_core.sv
// rlbg_core: register lock enforcement and nonvolatile busy gating for
// a two-wire temperature sensor target.
// assumes a byte-level front end that flags start, stop, address and
// received write bytes one cycle each, and waits for resp_valid.
// Summary of operation
// [R1] lock bit blocks all configuration and limit changes
// [R2] writing lock bit zero clears the lock
// [R3] locked nonvolatile config write changes only lock
// [R4] lockdown is one-time, blocks changes forever
// [R5] lockdown dominates; decode lock bits to three states
// [R6] lock state survives power, reset, general call
// [R7] disallowed command while busy gets NACK
// [R8] busy nonvolatile write: NACK after first data byte
// [R9] busy disallowed read: NACK after address byte
// [R10] pointer writes, temperature reads allowed while busy
// [R11] volatile reads allowed unless nv->v copy runs
// [R12] busy rejects writes, nv access, copies, ARA, general call
// [R13] master sends opcode in pointer byte position
// [R14] opcode leaves pointer register unchanged
// [R15] B8h copies nv to volatile, 48h reverse
// [R16] busy flag set throughout program or copy
// [R17] locked-out writes do nothing but still ACK
// [R18] copy starts at stop; repeated start aborts
// [R19] lock checks use current nv config at completion
`timescale 1ns/100ps
`default_nettype none
module rlbg_core #(
  parameter int NVCFG_W = rlbg_pkg::RLBG_NVCFG_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ev_start,
  input wire logic ev_stop,
  input wire logic ev_addr,
  input wire rlbg_pkg::rlbg_addr_e addr_kind,
  input wire logic addr_rd,
  input wire logic ev_byte,
  input wire logic [7:0] byte_data,
  input wire logic nv_lock,
  input wire logic nv_lockdown,
  input wire logic nv_done,
  input wire logic eeprom_busy,
  output logic resp_valid,
  output logic resp_ack,
  output logic [7:0] pointer,
  output logic op_start,
  output rlbg_pkg::rlbg_op_e op_kind,
  output logic [15:0] op_data,
  output logic op_lock_only,
  output logic nonvolatile_busy_flag,
  output logic copy_nv2v_run
);
  import rlbg_pkg::*;

  if (NVCFG_W != 16 || RLBG_LOCK_POS >= NVCFG_W || RLBG_LOCKDOWN_POS >= NVCFG_W) begin : g_bad_width
    $error("nonvolatile configuration width unsupported");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [3:0] {
    S_IDLE,
    S_PTR,
    S_HI,
    S_LO,
    S_DONE,
    S_CMD,
    S_GC,
    S_PASS,
    S_NACK
  } rlbg_state_e;

  typedef struct packed {
    rlbg_state_e st;
    logic [7:0] ptr;
    logic [7:0] hi;
    logic [7:0] lo;
    logic cmd_nv2v;
    logic busy;
    logic nv2v;
    logic resp_valid;
    logic resp_ack;
    logic op_start;
    rlbg_op_e op_kind;
    logic op_lock_only;
  } rlbg_regs_s;

  rlbg_regs_s r;
  rlbg_regs_s next_r;

  logic unlocked;
  logic lock_soft;
  logic lock_down;
  logic addr_ok;
  logic opc_ok;
  logic hi_ok;
  logic gc_ok;
  logic busy_any;
  logic [15:0] wdata;

  assign busy_any = r.busy || eeprom_busy;
  assign wdata = {r.hi, r.lo};

  ////////////////////////////////////////////////////////////////////////
  // lock status straight from nonvolatile cells; never reset here
  rlbg_lock_decode u_lock (
    .mclk(mclk),
    .rst_n(rst_n),
    .nv_lock(nv_lock), // R6 R19
    .nv_lockdown(nv_lockdown),
    .unlocked(unlocked),
    .lock_soft(lock_soft),
    .lock_down(lock_down)
  );

  rlbg_busy_gate u_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .busy(busy_any),
    .nv2v_run(r.busy && r.nv2v),
    .addr_kind(addr_kind),
    .addr_rd(addr_rd),
    .ptr(r.ptr),
    .byte_data(byte_data),
    .addr_ok(addr_ok),
    .opc_ok(opc_ok),
    .hi_ok(hi_ok),
    .gc_ok(gc_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // transfer tracking and commit decisions
  always_comb begin
    next_r = r;
    next_r.resp_valid = 1'h0;
    next_r.op_start = 1'h0;
    next_r.op_kind = RLBG_OP_NONE;
    next_r.op_lock_only = 1'h0;
    if (nv_done) begin
      next_r.busy = 1'h0;
    end
    if (ev_start) begin
      next_r.st = S_IDLE; // R18
    end else if (ev_stop) begin
      next_r.st = S_IDLE;
      if (r.st == S_DONE && !busy_any) begin
        if (rlbg_is_vol(r.ptr) && unlocked) begin // R1 R4 R17 R19
          next_r.op_start = 1'h1;
          next_r.op_kind = RLBG_OP_VOL_WR;
        end else if (rlbg_is_nv(r.ptr) && unlocked) begin // R1 R19
          next_r.op_start = 1'h1;
          next_r.op_kind = RLBG_OP_NV_WR;
          next_r.busy = 1'h1; // R16
          next_r.nv2v = 1'h0;
        end else if (lock_soft && r.ptr == RLBG_PTR_NVCFG && !wdata[RLBG_LOCK_POS]) begin // R2 R3
          next_r.op_start = 1'h1;
          next_r.op_kind = RLBG_OP_NV_WR;
          next_r.op_lock_only = 1'h1; // R3
          next_r.busy = 1'h1; // R16
          next_r.nv2v = 1'h0;
        end
      end else if (r.st == S_CMD && !busy_any && unlocked) begin // R18 R19
        next_r.op_start = 1'h1;
        next_r.op_kind = r.cmd_nv2v ? RLBG_OP_COPY_NV2V : RLBG_OP_COPY_V2NV; // R15
        next_r.busy = 1'h1; // R16
        next_r.nv2v = r.cmd_nv2v;
      end
    end else if (ev_addr) begin
      next_r.resp_valid = 1'h1;
      next_r.resp_ack = addr_ok; // R7 R9 R10 R11
      if (!addr_ok) begin
        next_r.st = S_NACK;
      end else if (addr_kind == RLBG_ADDR_OWN && !addr_rd) begin
        next_r.st = S_PTR; // R13
      end else if (addr_kind == RLBG_ADDR_GCALL) begin
        next_r.st = S_GC;
      end else begin
        next_r.st = S_PASS;
      end
    end else if (ev_byte) begin
      next_r.resp_valid = 1'h1;
      next_r.resp_ack = 1'h1;
      case (r.st)
        S_PTR: begin
          if (rlbg_is_opc(byte_data)) begin // R13 R14
            next_r.resp_ack = opc_ok; // R12
            next_r.cmd_nv2v = (byte_data == RLBG_OPC_COPY_NV2V); // R15
            next_r.st = opc_ok ? S_CMD : S_NACK;
          end else begin
            next_r.ptr = byte_data; // R10
            next_r.st = S_HI;
          end
        end
        S_HI: begin
          next_r.resp_ack = hi_ok; // R8
          next_r.hi = byte_data;
          next_r.st = hi_ok ? S_LO : S_NACK;
        end
        S_LO: begin
          next_r.lo = byte_data;
          next_r.st = S_DONE;
        end
        S_GC: begin
          next_r.resp_ack = gc_ok; // R12
          next_r.st = gc_ok ? S_PASS : S_NACK;
        end
        S_DONE, S_CMD, S_PASS: next_r.resp_ack = 1'h1; // R17
        S_NACK, S_IDLE: next_r.resp_ack = 1'h0; // R7
        default: next_r.resp_ack = 1'h0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign resp_valid = r.resp_valid;
  assign resp_ack = r.resp_ack;
  assign pointer = r.ptr;
  assign op_start = r.op_start;
  assign op_kind = r.op_kind;
  assign op_data = wdata;
  assign op_lock_only = r.op_lock_only;
  assign nonvolatile_busy_flag = r.busy;
  assign copy_nv2v_run = r.busy && r.nv2v;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_write_done;
    r.st == S_DONE && ev_stop && !ev_start && !busy_any;
  endsequence

  sequence s_copy_cmd;
    r.st == S_CMD && ev_stop && !ev_start && !busy_any && unlocked;
  endsequence

  chk_lock_blocks_vol: assert property ( // R1
    (s_write_done and (!unlocked && rlbg_is_vol(r.ptr))) |=> !op_start)
    else $error("volatile write committed while locked");
  chk_lockdown_blocks: assert property ( // R4
    (ev_stop && !ev_start && nv_lockdown) |=> !op_start)
    else $error("operation started under lockdown");
  chk_lock_only_write: assert property ( // R3
    op_lock_only |-> (op_kind == RLBG_OP_NV_WR && !op_data[RLBG_LOCK_POS]
                      && $past(lock_soft) && $past(r.ptr) == RLBG_PTR_NVCFG))
    else $error("lock-only write without soft lock");
  chk_unlock_clears: assert property ( // R2
    (s_write_done and (lock_soft && r.ptr == RLBG_PTR_NVCFG && !wdata[RLBG_LOCK_POS]))
    |=> op_start && op_lock_only && nonvolatile_busy_flag)
    else $error("lock clear write not carried out");
  chk_busy_hi_nack: assert property ( // R8
    (r.st == S_HI && ev_byte && !ev_start && !ev_stop && busy_any && rlbg_is_nv(r.ptr))
    |=> resp_valid && !resp_ack && r.st == S_NACK)
    else $error("busy nonvolatile write not refused at first data byte");
  chk_opcode_keeps_ptr: assert property ( // R14
    (r.st == S_PTR && ev_byte && !ev_start && !ev_stop && rlbg_is_opc(byte_data))
    |=> $stable(pointer))
    else $error("opcode changed the pointer");
  chk_copy_decode: assert property ( // R15
    s_copy_cmd |=> op_start && copy_nv2v_run == (op_kind == RLBG_OP_COPY_NV2V)
                   && op_kind != RLBG_OP_NONE)
    else $error("copy command decoded wrongly");
  chk_rstart_abort: assert property ( // R18
    (r.st == S_CMD && ev_start) |=> !op_start [*2])
    else $error("copy started after repeated start");
  chk_busy_holds: assert property ( // R16
    (nonvolatile_busy_flag && !nv_done) |=> nonvolatile_busy_flag)
    else $error("busy flag dropped before completion");
  chk_busy_copy_nack: assert property ( // R12
    (r.st == S_PTR && ev_byte && !ev_start && !ev_stop && busy_any
     && rlbg_is_opc(byte_data)) |=> resp_valid && !resp_ack)
    else $error("copy command accepted while busy");
  chk_nack_sticky: assert property ( // R7
    (r.st == S_NACK && ev_byte && !ev_start && !ev_stop && !ev_addr) |=> resp_valid && !resp_ack)
    else $error("byte after refusal acknowledged");
  chk_busy_no_commit: assert property ( // R12
    (ev_stop && !ev_start && busy_any) |=> !op_start)
    else $error("operation committed while busy");
  chk_vol_read_copy: assert property ( // R11
    (ev_addr && !ev_start && !ev_stop && addr_kind == RLBG_ADDR_OWN && addr_rd
     && copy_nv2v_run && rlbg_is_vol(pointer)) |=> resp_valid && !resp_ack)
    else $error("volatile read accepted during nv to volatile copy");
  chk_ptr_write_ack: assert property ( // R10
    (r.st == S_PTR && ev_byte && !ev_start && !ev_stop && !ev_addr && !rlbg_is_opc(byte_data))
    |=> resp_valid && resp_ack && pointer == $past(byte_data))
    else $error("pointer write refused or lost");
  chk_busy_on_start: assert property ( // R16
    (op_start && op_kind != RLBG_OP_VOL_WR) |-> nonvolatile_busy_flag)
    else $error("nonvolatile operation started without busy flag");

endmodule : rlbg_core
`default_nettype wire

// ===== core/rlbg_pkg.sv
// rlbg_pkg: constants, types and decode functions shared by the
// register lock and busy gating logic.
// assumes a byte-level two-wire front end and a nonvolatile cell store.
package rlbg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register pointers
  localparam logic [7:0] RLBG_PTR_TEMP = 8'h00;
  localparam logic [7:0] RLBG_PTR_CFG = 8'h01;
  localparam logic [7:0] RLBG_PTR_TLOW = 8'h02;
  localparam logic [7:0] RLBG_PTR_THIGH = 8'h03;
  localparam logic [7:0] RLBG_PTR_NVCFG = 8'h11;
  localparam logic [7:0] RLBG_PTR_NVTLOW = 8'h12;
  localparam logic [7:0] RLBG_PTR_NVTHIGH = 8'h13;

  ////////////////////////////////////////////////////////////////////////
  // command opcodes and general call bytes
  localparam logic [7:0] RLBG_OPC_COPY_NV2V = 8'hB8;
  localparam logic [7:0] RLBG_OPC_COPY_V2NV = 8'h48;
  localparam logic [7:0] RLBG_GC_LATCH = 8'h04;
  localparam logic [7:0] RLBG_GC_RESET = 8'h06;

  ////////////////////////////////////////////////////////////////////////
  // nonvolatile configuration word layout
  localparam int RLBG_NVCFG_W = 16;
  localparam int RLBG_LOCK_POS = 2;
  localparam int RLBG_LOCKDOWN_POS = 1;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    RLBG_ADDR_OWN,
    RLBG_ADDR_EEPROM,
    RLBG_ADDR_ARA,
    RLBG_ADDR_GCALL
  } rlbg_addr_e;

  typedef enum logic [2:0] {
    RLBG_OP_NONE,
    RLBG_OP_VOL_WR,
    RLBG_OP_NV_WR,
    RLBG_OP_COPY_NV2V,
    RLBG_OP_COPY_V2NV
  } rlbg_op_e;

  ////////////////////////////////////////////////////////////////////////
  // decode functions
  function automatic logic rlbg_is_vol(input logic [7:0] p);
    return (p == RLBG_PTR_CFG) || (p == RLBG_PTR_TLOW) || (p == RLBG_PTR_THIGH);
  endfunction : rlbg_is_vol

  function automatic logic rlbg_is_nv(input logic [7:0] p);
    return (p == RLBG_PTR_NVCFG) || (p == RLBG_PTR_NVTLOW) || (p == RLBG_PTR_NVTHIGH);
  endfunction : rlbg_is_nv

  function automatic logic rlbg_is_opc(input logic [7:0] b);
    return (b == RLBG_OPC_COPY_NV2V) || (b == RLBG_OPC_COPY_V2NV);
  endfunction : rlbg_is_opc

endpackage : rlbg_pkg

// ===== core/rlbg_lock_decode.sv
// rlbg_lock_decode: turns the two lock bits of the nonvolatile
// configuration word into a lock status.
// assumes both bits come straight from the nonvolatile cell store.
`timescale 1ns/100ps
`default_nettype none
module rlbg_lock_decode (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic nv_lock,
  input wire logic nv_lockdown,
  output logic unlocked,
  output logic lock_soft,
  output logic lock_down
);
  import rlbg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // lockdown dominates the reversible lock
  always_comb begin
    lock_down = nv_lockdown; // R5
    lock_soft = nv_lock && !nv_lockdown; // R5
    unlocked = !nv_lock && !nv_lockdown; // R5
  end

  ////////////////////////////////////////////////////////////////////////
  chk_lockdown_dominant: assert property (@(posedge mclk) disable iff (!rst_n) // R5
    nv_lockdown |-> (lock_down && !lock_soft && !unlocked))
    else $error("lockdown does not dominate lock");
  chk_status_onehot: assert property (@(posedge mclk) disable iff (!rst_n) // R5
    $onehot({unlocked, lock_soft, lock_down}))
    else $error("lock status not one-hot");

endmodule : rlbg_lock_decode
`default_nettype wire

// ===== core/rlbg_busy_gate.sv
// rlbg_busy_gate: decides which transfers may be acknowledged while a
// nonvolatile operation runs.
// assumes the busy inputs are registered flags of the caller.
`timescale 1ns/100ps
`default_nettype none
module rlbg_busy_gate (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic nv2v_run,
  input wire rlbg_pkg::rlbg_addr_e addr_kind,
  input wire logic addr_rd,
  input wire logic [7:0] ptr,
  input wire logic [7:0] byte_data,
  output logic addr_ok,
  output logic opc_ok,
  output logic hi_ok,
  output logic gc_ok
);
  import rlbg_pkg::*;

  logic rd_ok;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    // temperature always readable, volatile set unless nv->v copy runs
    rd_ok = (ptr == RLBG_PTR_TEMP) || (rlbg_is_vol(ptr) && !nv2v_run); // R10 R11
    case (addr_kind)
      RLBG_ADDR_OWN: addr_ok = !busy || !addr_rd || rd_ok; // R9 R10
      RLBG_ADDR_GCALL: addr_ok = 1'h1;
      default: addr_ok = !busy; // R12
    endcase
    opc_ok = !busy; // R12
    hi_ok = !busy || !(rlbg_is_vol(ptr) || rlbg_is_nv(ptr)); // R8 R12
    gc_ok = !busy || !((byte_data == RLBG_GC_LATCH) || (byte_data == RLBG_GC_RESET)); // R12
  end

  ////////////////////////////////////////////////////////////////////////
  chk_nv_read_busy: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    (busy && addr_kind == RLBG_ADDR_OWN && addr_rd && rlbg_is_nv(ptr)) |-> !addr_ok)
    else $error("nonvolatile read accepted while busy");
  chk_temp_read: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    (addr_kind == RLBG_ADDR_OWN && ptr == RLBG_PTR_TEMP) |-> addr_ok)
    else $error("temperature read refused");

endmodule : rlbg_busy_gate
`default_nettype wire

// ===== tb/rlbg_far_model.sv
// rlbg_far_model: byte-level two-wire master and nonvolatile cell store.
// assumes the core answers each address or byte event one cycle later.
`timescale 1ns/100ps
`default_nettype none
module rlbg_far_model (
  input wire logic mclk,
  input wire logic resp_valid,
  input wire logic resp_ack,
  input wire logic [7:0] pointer,
  input wire logic op_start,
  input wire rlbg_pkg::rlbg_op_e op_kind,
  input wire logic [15:0] op_data,
  input wire logic op_lock_only,
  output logic ev_start,
  output logic ev_stop,
  output logic ev_addr,
  output rlbg_pkg::rlbg_addr_e addr_kind,
  output logic addr_rd,
  output logic ev_byte,
  output logic [7:0] byte_data,
  output logic nv_lock,
  output logic nv_lockdown,
  output logic nv_done
);
  import rlbg_pkg::*;
  int done_dly = 20;
  int cnt = 0;
  initial begin
    {ev_start, ev_stop, ev_addr, addr_rd, ev_byte, nv_done} = 6'h00;
    addr_kind = RLBG_ADDR_OWN;
    byte_data = 8'h00;
    nv_lock = 1'b0;
    nv_lockdown = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // cell store: no reset input, so lock state outlives any reset
  always @(negedge mclk) begin
    nv_done <= (cnt == 1);
    if (cnt != 0) begin
      cnt <= cnt - 1;
    end
    if (op_start && op_kind != RLBG_OP_VOL_WR) begin
      cnt <= done_dly;
    end
    if (op_start && op_kind == RLBG_OP_NV_WR && pointer == RLBG_PTR_NVCFG) begin
      nv_lock <= op_data[RLBG_LOCK_POS];
      if (!op_lock_only) begin
        nv_lockdown <= nv_lockdown | op_data[RLBG_LOCKDOWN_POS];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // k: 0 start, 1 stop, 2 address, 3 byte; data inverted once released
  task automatic ev(input int k, input logic [7:0] d, input rlbg_addr_e ak,
                    input logic rd, output logic ack);
    @(negedge mclk);
    ev_start <= (k == 0);
    ev_stop <= (k == 1);
    ev_addr <= (k == 2);
    ev_byte <= (k == 3);
    addr_kind <= ak;
    addr_rd <= rd;
    byte_data <= d;
    @(negedge mclk);
    ack = (resp_valid === 1'b1) ? resp_ack : 1'bx;
    {ev_start, ev_stop, ev_addr, ev_byte} <= 4'h0;
    byte_data <= ~d;
    @(negedge mclk);
  endtask : ev
endmodule : rlbg_far_model
`default_nettype wire

// ===== tb/testbench.sv
// testbench: scenarios for lock enforcement and busy gating of rlbg_core.
// assumes rlbg_far_model plays the bus master and the cell store.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rlbg_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic eeprom_busy = 1'b0;
  logic ev_start, ev_stop, ev_addr, addr_rd, ev_byte, nv_lock, nv_lockdown, nv_done;
  logic resp_valid, resp_ack, op_start, op_lock_only, busy, run, a, last_lo;
  rlbg_addr_e addr_kind;
  rlbg_op_e op_kind, last_kind;
  logic [7:0] byte_data, pointer;
  logic [15:0] op_data, last_data;
  logic [3:0] acks;
  int err_count = 0;
  int checks = 0;
  int n_ops = 0;
  int cyc = 0;

  rlbg_core rlbg_core_i (.mclk(mclk), .rst_n(rst_n), .ev_start(ev_start),
    .ev_stop(ev_stop), .ev_addr(ev_addr), .addr_kind(addr_kind), .addr_rd(addr_rd),
    .ev_byte(ev_byte), .byte_data(byte_data), .nv_lock(nv_lock),
    .nv_lockdown(nv_lockdown), .nv_done(nv_done), .eeprom_busy(eeprom_busy),
    .resp_valid(resp_valid), .resp_ack(resp_ack), .pointer(pointer),
    .op_start(op_start), .op_kind(op_kind), .op_data(op_data),
    .op_lock_only(op_lock_only), .nonvolatile_busy_flag(busy), .copy_nv2v_run(run));

  rlbg_far_model rlbg_far_model_i (.mclk(mclk), .resp_valid(resp_valid),
    .resp_ack(resp_ack), .pointer(pointer), .op_start(op_start), .op_kind(op_kind),
    .op_data(op_data), .op_lock_only(op_lock_only), .ev_start(ev_start),
    .ev_stop(ev_stop), .ev_addr(ev_addr), .addr_kind(addr_kind), .addr_rd(addr_rd),
    .ev_byte(ev_byte), .byte_data(byte_data), .nv_lock(nv_lock),
    .nv_lockdown(nv_lockdown), .nv_done(nv_done));

  always #2.5 mclk = ~mclk;

  always @(negedge mclk) begin
    cyc++;
    if (op_start === 1'b1) begin
      n_ops++;
      last_kind = op_kind;
      last_data = op_data;
      last_lo = op_lock_only;
    end
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic e(input int k, input logic [7:0] d = 8'h00,
                   input rlbg_addr_e ak = RLBG_ADDR_OWN, input logic rd = 1'b0);
    rlbg_far_model_i.ev(k, d, ak, rd, a);
  endtask : e

  // acks holds {address, pointer, upper, lower}; fin 0 ends on repeated start
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d,
                    input logic fin);
    n_ops = 0;
    acks = 4'h0;
    e(0);
    e(2);
    acks[3] = a;
    e(3, p);
    acks[2] = a;
    if (n > 0) begin
      e(3, d[15:8]);
      acks[1] = a;
    end
    if (n > 1) begin
      e(3, d[7:0]);
      acks[0] = a;
    end
    if (!fin) begin
      e(0);
    end
    e(1);
  endtask : wr

  task automatic rdx(input rlbg_addr_e ak, input logic x, input string nm);
    e(0);
    e(2, 8'h00, ak, 1'b1);
    chk(nm, 16'(x), 16'(a));
    e(1);
  endtask : rdx

  task automatic wait_idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) begin
      @(negedge mclk);
    end
    chk("idle", 16'h0, 16'(busy));
  endtask : wait_idle

  task automatic rst();
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
  endtask : rst
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_plain();
    chk("pointer", 16'h0, 16'(pointer));
    chk("busy", 16'h0, 16'(busy));
    wr(RLBG_PTR_CFG, 2, 16'hABCD, 1'b1);
    chk("acks", 16'hF, 16'(acks));
    chk("kind", 16'(RLBG_OP_VOL_WR), 16'(last_kind));
    chk("data", 16'hABCD, last_data);
    chk("busy", 16'h0, 16'(busy));
    wr(RLBG_PTR_TLOW, 1, 16'h1200, 1'b1);
    chk("ops", 16'h0, 16'(n_ops));
    wr(RLBG_PTR_THIGH, 2, 16'h1234, 1'b0);
    chk("ops", 16'h0, 16'(n_ops));
    $display("test plain done");
  endtask : t_plain

  task automatic t_busy();
    rlbg_far_model_i.done_dly = 400;
    wr(RLBG_PTR_NVTLOW, 2, 16'h1234, 1'b1);
    chk("kind", 16'(RLBG_OP_NV_WR), 16'(last_kind));
    chk("busy", 16'h1, 16'(busy));
    wr(RLBG_PTR_TEMP, 0, 16'h0, 1'b1);
    chk("acks", 16'hC, 16'(acks));
    rdx(RLBG_ADDR_OWN, 1'b1, "temp read");
    wr(RLBG_PTR_CFG, 0, 16'h0, 1'b1);
    rdx(RLBG_ADDR_OWN, 1'b1, "cfg read");
    wr(RLBG_PTR_NVCFG, 0, 16'h0, 1'b1);
    rdx(RLBG_ADDR_OWN, 1'b0, "nv read");
    wr(RLBG_PTR_THIGH, 2, 16'h1111, 1'b1);
    chk("acks", 16'hC, 16'(acks));
    wr(RLBG_PTR_NVTHIGH, 2, 16'h2222, 1'b1);
    chk("acks", 16'hC, 16'(acks));
    chk("ops", 16'h0, 16'(n_ops));
    wr(RLBG_OPC_COPY_NV2V, 0, 16'h0, 1'b1);
    chk("acks", 16'h8, 16'(acks));
    wr(RLBG_OPC_COPY_V2NV, 0, 16'h0, 1'b1);
    chk("acks", 16'h8, 16'(acks));
    chk("pointer", 16'(RLBG_PTR_NVTHIGH), 16'(pointer));
    rdx(RLBG_ADDR_EEPROM, 1'b0, "eeprom");
    rdx(RLBG_ADDR_ARA, 1'b0, "ara");
    for (int g = 0; g < 2; g++) begin
      e(0);
      e(2, 8'h00, RLBG_ADDR_GCALL);
      e(3, g ? RLBG_GC_RESET : RLBG_GC_LATCH);
      chk("gcall", 16'h0, 16'(a));
      e(1);
    end
    chk("busy", 16'h1, 16'(busy));
    wait_idle();
    eeprom_busy = 1'b1;
    rdx(RLBG_ADDR_OWN, 1'b0, "eeprom busy read");
    eeprom_busy = 1'b0;
    rdx(RLBG_ADDR_OWN, 1'b1, "idle read");
    $display("test busy done");
  endtask : t_busy

  task automatic t_copy();
    rlbg_far_model_i.done_dly = 30;
    wr(RLBG_PTR_CFG, 0, 16'h0, 1'b1);
    wr(RLBG_OPC_COPY_NV2V, 0, 16'h0, 1'b1);
    chk("kind", 16'(RLBG_OP_COPY_NV2V), 16'(last_kind));
    chk("run", 16'h1, 16'(run));
    chk("pointer", 16'(RLBG_PTR_CFG), 16'(pointer));
    rdx(RLBG_ADDR_OWN, 1'b0, "cfg read in copy");
    wait_idle();
    wr(RLBG_OPC_COPY_V2NV, 0, 16'h0, 1'b1);
    chk("kind", 16'(RLBG_OP_COPY_V2NV), 16'(last_kind));
    chk("run", 16'h0, 16'(run));
    wait_idle();
    wr(RLBG_OPC_COPY_NV2V, 0, 16'h0, 1'b0);
    chk("ops", 16'h0, 16'(n_ops));
    $display("test copy done");
  endtask : t_copy

  task automatic t_lock();
    rlbg_far_model_i.done_dly = 10;
    wr(RLBG_PTR_NVCFG, 2, 16'h0004, 1'b1);
    wait_idle();
    rst();
    wr(RLBG_PTR_CFG, 2, 16'h1111, 1'b1);
    chk("acks", 16'hF, 16'(acks));
    chk("ops", 16'h0, 16'(n_ops));
    wr(RLBG_OPC_COPY_V2NV, 0, 16'h0, 1'b1);
    chk("ops", 16'h0, 16'(n_ops));
    wr(RLBG_PTR_NVCFG, 2, 16'hFF00, 1'b1);
    chk("lock only", 16'h1, 16'(last_lo));
    chk("ops", 16'h1, 16'(n_ops));
    wait_idle();
    wr(RLBG_PTR_CFG, 2, 16'h1111, 1'b1);
    chk("ops", 16'h1, 16'(n_ops));
    $display("test lock done");
  endtask : t_lock

  task automatic t_lockdown();
    wr(RLBG_PTR_NVCFG, 2, 16'h0002, 1'b1);
    wait_idle();
    wr(RLBG_PTR_NVCFG, 2, 16'h0000, 1'b1);
    chk("acks", 16'hF, 16'(acks));
    chk("ops", 16'h0, 16'(n_ops));
    wr(RLBG_PTR_NVTLOW, 2, 16'h1000, 1'b1);
    chk("ops", 16'h0, 16'(n_ops));
    rst();
    wr(RLBG_PTR_CFG, 2, 16'h1111, 1'b1);
    chk("ops", 16'h0, 16'(n_ops));
    $display("test lockdown done");
  endtask : t_lockdown

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    t_plain();
    t_busy();
    t_copy();
    t_lock();
    t_lockdown();
    summarize();
  end
endmodule : testbench
`default_nettype wire
